// ### verilog/fsp_flash_ctrl.v
// Purpose: Flash self-read, row erase, latch load and row program control.
// Assumes: One clk cycle is one instruction cycle; array answers reads
// within one cycle of the read strobe.
// Notes: Bus accesses are held off (no ack) while an operation runs,
// which is how the core sees forced no-ops and the timed stall.
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_defines.vh"

// Functional notes
// R1: Data pair holds one 14-bit word.
// R2: Address pair forms 15-bit address, high bits high.
// R3: Internal timer sets erase and program length.
// R4: Code protect blocks programmer read and write only.
// R5: Only programmer bulk erase removes code protect; power-on reset here also clears it.
// R6: Write-protect field blocks self erase and program.
// R7: Read and write triggers only set; hardware clears.
// R8: Write needs write allow; allow cleared at power-up.
// R9: Reset during write sets abort flag.
// R10: Unlock register reads as zero.
// R11: Rows of 32 words, 32 latches.
// R12: Latches loaded only through the data pair.
// R13: Software loads address, clears config select, sets read.
// R14: Second cycle reads array; data next cycle.
// R15: Data pair holds until next read or write.
// R16: Software places no-ops after read trigger.
// R17: Latch and array writes need completed unlock.
// R18: Software writes 55h, AAh, then write trigger.
// R19: Write trigger forces two no-op cycles.
// R20: Erase or program stalls core for timed operation.
// R21: Latch load forces no-ops, no stall.
// R22: Software masks interrupts around unlock.
// R23: Erase select makes unlock erase addressed row.
// R24: Latch-only select loads latch, else programs row.
// R25: High ten bits pick row, low five pick latch.
// R26: Latches return to blank after program or erase.
// R27: Any other access restarts the unlock detector.
module fsp_flash_ctrl #(
	parameter [17:0] OP_CYCLES = `FSP_OP_CYCLES
) (
	input wire clk,
	input wire resetn,
	input wire porn,
	input wire [7:0] adr_i,
	input wire [31:0] dat_i,
	input wire we_i,
	input wire [3:0] sel_i,
	input wire cyc_i,
	input wire stb_i,
	output reg ack_o,
	output reg [31:0] dat_o,
	output reg cpuForceNop,
	output reg cpuStall,
	output reg [14:0] flashAddr,
	output reg [13:0] flashWdata,
	output reg flashCfgSpace,
	output reg flashRdStrobe,
	output reg flashWrStrobe,
	output reg flashEraseStrobe,
	output reg flashBulkStrobe,
	input wire [13:0] flashRdata,
	input wire progReq,
	input wire [1:0] progOp,
	input wire [14:0] progAddr,
	input wire [13:0] progWdata,
	output reg progAck,
	output reg progDenied,
	output reg [13:0] progRdata
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RD1 = 3'h1;
	localparam [2:0] ST_RD2 = 3'h2;
	localparam [2:0] ST_NOP1 = 3'h3;
	localparam [2:0] ST_NOP2 = 3'h4;
	localparam [2:0] ST_STREAM = 3'h5;
	localparam [2:0] ST_WAIT = 3'h6;
	localparam [2:0] ST_PRD = 3'h7;

	function [3:0] fsp_dec;
		input [7:0] a;
		begin
			if (a == `FSP_OFF_ADDR_LOW) begin
				fsp_dec = `FSP_SEL_ADDR_LOW;
			end else if (a == `FSP_OFF_ADDR_HIGH) begin
				fsp_dec = `FSP_SEL_ADDR_HIGH;
			end else if (a == `FSP_OFF_DATA_LOW) begin
				fsp_dec = `FSP_SEL_DATA_LOW;
			end else if (a == `FSP_OFF_DATA_HIGH) begin
				fsp_dec = `FSP_SEL_DATA_HIGH;
			end else if (a == `FSP_OFF_CTRL) begin
				fsp_dec = `FSP_SEL_CTRL;
			end else if (a == `FSP_OFF_UNLOCK) begin
				fsp_dec = `FSP_SEL_UNLOCK;
			end else if (a == `FSP_OFF_CONFIG) begin
				fsp_dec = `FSP_SEL_CONFIG;
			end else if (a == `FSP_OFF_STATUS) begin
				fsp_dec = `FSP_SEL_STATUS;
			end else begin
				fsp_dec = `FSP_SEL_NONE;
			end
		end
	endfunction

	// True when the address lies in the write-protected span.
	function fsp_wp;
		input [1:0] wpSel;
		input [14:0] a;
		begin
			if (wpSel == `FSP_WP_OFF) begin
				fsp_wp = 1'b0;
			end else if (wpSel == `FSP_WP_LOW) begin
				fsp_wp = (a < `FSP_WP_LOW_END);
			end else if (wpSel == `FSP_WP_HALF) begin
				fsp_wp = (a < `FSP_WP_HALF_END);
			end else begin
				fsp_wp = 1'b1;
			end
		end
	endfunction

	reg [2:0] stateQ;
	reg [1:0] unlockStageQ;
	reg [7:0] addrLowQ;
	reg [6:0] addrHighQ;
	reg [7:0] dataLowQ;
	reg [5:0] dataHighQ;
	reg readQ;
	reg writeQ;
	reg allowQ;
	reg abortQ;
	reg latchOnlyQ;
	reg eraseQ;
	reg cfgSelQ;
	reg codeProtectNQ;
	reg [1:0] writeProtectQ;
	reg [4:0] latchIdxQ;
	reg [17:0] timerQ;
	reg progRdWaitQ;
	reg [7:0] rdByte;
	wire [3:0] regSel;
	wire access;
	wire wrAccess;
	wire [7:0] wByte;
	wire [14:0] wordAddr;
	wire armed;
	wire progTake;
	wire latchLoad;
	wire latchClear;
	wire [14*`FSP_LATCH_COUNT-1:0] latchBus;

	assign regSel = fsp_dec(adr_i);
	assign access = cyc_i & stb_i & ~ack_o & (stateQ == ST_IDLE);
	assign wrAccess = access & we_i & sel_i[0];
	assign wByte = dat_i[7:0];
	assign wordAddr = {addrHighQ, addrLowQ}; // R2
	assign armed = (unlockStageQ == 2'h2);
	// The requester still holds progReq in the acknowledge cycle, so it must not count twice.
	assign progTake = progReq & ~progAck & ~access & (stateQ == ST_IDLE);
	assign latchLoad = (stateQ == ST_NOP2) & latchOnlyQ; // R21 R24
	assign latchClear = (stateQ == ST_WAIT) & (timerQ == OP_CYCLES - 18'h1); // R26

	// Each latch only takes the data pair at the end of an unlocked load.
	genvar gi;
	generate
		for (gi = 0; gi < `FSP_LATCH_COUNT; gi = gi + 1) begin : gLatch
			reg [13:0] wordQ;
			always @(posedge clk) begin
				if (!resetn || latchClear) begin
					wordQ <= `FSP_LATCH_BLANK; // R26
				end else if (latchLoad && addrLowQ[4:0] == gi) begin
					wordQ <= {dataHighQ, dataLowQ}; // R12 R25
				end
			end
			assign latchBus[gi*14 +: 14] = wordQ; // R11
		end
	endgenerate

	always @* begin
		rdByte = 8'h00;
		if (regSel == `FSP_SEL_ADDR_LOW) begin
			rdByte = addrLowQ;
		end else if (regSel == `FSP_SEL_ADDR_HIGH) begin
			rdByte = {1'b0, addrHighQ};
		end else if (regSel == `FSP_SEL_DATA_LOW) begin
			rdByte = dataLowQ;
		end else if (regSel == `FSP_SEL_DATA_HIGH) begin
			rdByte = {2'h0, dataHighQ}; // R1
		end else if (regSel == `FSP_SEL_CTRL) begin
			rdByte = {1'b0, cfgSelQ, eraseQ, latchOnlyQ, abortQ, allowQ, writeQ, readQ};
		end else if (regSel == `FSP_SEL_UNLOCK) begin
			rdByte = 8'h00; // R10
		end else if (regSel == `FSP_SEL_CONFIG) begin
			rdByte = {5'h00, codeProtectNQ, writeProtectQ};
		end else if (regSel == `FSP_SEL_STATUS) begin
			rdByte = {5'h00, cpuStall, unlockStageQ};
		end
	end

	// Bus answer: one cycle after the request, and only while idle.
	always @(posedge clk) begin
		if (!resetn) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			unlockStageQ <= 2'h0;
		end else begin
			ack_o <= access;
			if (access && !we_i) begin
				dat_o <= {24'h00_0000, rdByte};
			end else begin
				dat_o <= 32'h0000_0000;
			end
			if (wrAccess && regSel == `FSP_SEL_UNLOCK && wByte == `FSP_KEY_FIRST) begin
				unlockStageQ <= 2'h1;
			end else if (wrAccess && regSel == `FSP_SEL_UNLOCK && wByte == `FSP_KEY_SECOND
				&& unlockStageQ == 2'h1) begin
				unlockStageQ <= 2'h2;
			end else if (access) begin
				unlockStageQ <= 2'h0; // R27
			end
		end
	end

	always @(posedge clk) begin
		flashRdStrobe <= 1'b0;
		flashWrStrobe <= 1'b0;
		flashEraseStrobe <= 1'b0;
		flashBulkStrobe <= 1'b0;
		progAck <= 1'b0;
		if (!porn || !resetn) begin
			// Config bits persist over a plain reset.
			if (!porn) begin
				codeProtectNQ <= 1'b1;
				writeProtectQ <= `FSP_WP_OFF;
				abortQ <= 1'b0;
			end else begin
				abortQ <= abortQ | writeQ; // R9
			end
			stateQ <= ST_IDLE;
			addrLowQ <= 8'h00;
			addrHighQ <= 7'h00;
			dataLowQ <= 8'h00;
			dataHighQ <= 6'h00;
			readQ <= 1'b0;
			writeQ <= 1'b0;
			allowQ <= 1'b0; // R8
			latchOnlyQ <= 1'b0;
			eraseQ <= 1'b0;
			cfgSelQ <= 1'b0;
			latchIdxQ <= 5'h00;
			timerQ <= 18'h00000;
			progRdWaitQ <= 1'b0;
			cpuForceNop <= 1'b0;
			cpuStall <= 1'b0;
			flashAddr <= 15'h0000;
			flashWdata <= 14'h0000;
			flashCfgSpace <= 1'b0;
			progDenied <= 1'b0;
			progRdata <= 14'h0000;
		end else begin
			case (stateQ)
				ST_IDLE: begin
					if (wrAccess) begin
						if (regSel == `FSP_SEL_ADDR_LOW) begin
							addrLowQ <= wByte;
						end else if (regSel == `FSP_SEL_ADDR_HIGH) begin
							addrHighQ <= wByte[6:0];
						end else if (regSel == `FSP_SEL_DATA_LOW) begin
							dataLowQ <= wByte; // R15
						end else if (regSel == `FSP_SEL_DATA_HIGH) begin
							dataHighQ <= wByte[5:0];
						end else if (regSel == `FSP_SEL_CTRL) begin
							allowQ <= wByte[`FSP_BIT_ALLOW];
							latchOnlyQ <= wByte[`FSP_BIT_LATCH_ONLY];
							eraseQ <= wByte[`FSP_BIT_ERASE];
							cfgSelQ <= wByte[`FSP_BIT_CFG_SEL];
							abortQ <= abortQ & wByte[`FSP_BIT_ABORT];
							// Writing zero to a trigger does nothing.
							if (wByte[`FSP_BIT_READ]) begin
								readQ <= 1'b1; // R7
								stateQ <= ST_RD1;
								cpuForceNop <= 1'b1;
								flashAddr <= wordAddr;
								flashCfgSpace <= wByte[`FSP_BIT_CFG_SEL];
								flashRdStrobe <= 1'b1;
							end else if (wByte[`FSP_BIT_WRITE] && armed && allowQ
								&& (wByte[`FSP_BIT_LATCH_ONLY]
								|| wByte[`FSP_BIT_CFG_SEL]
								|| !fsp_wp(writeProtectQ, wordAddr))) begin // R6 R8 R17
								writeQ <= 1'b1; // R7
								stateQ <= ST_NOP1;
								cpuForceNop <= 1'b1; // R19
								flashCfgSpace <= wByte[`FSP_BIT_CFG_SEL];
							end
						end
					end else if (progTake) begin
						progAck <= 1'b1;
						progDenied <= 1'b0;
						flashCfgSpace <= 1'b0;
						if (progOp == `FSP_PROG_BULK) begin
							flashBulkStrobe <= 1'b1; // R5
							codeProtectNQ <= 1'b1;
							writeProtectQ <= `FSP_WP_OFF;
						end else if (progOp == `FSP_PROG_CONFIG) begin
							codeProtectNQ <= codeProtectNQ & progWdata[2]; // R5
							writeProtectQ <= progWdata[1:0];
						end else if (!codeProtectNQ) begin
							progDenied <= 1'b1; // R4
						end else if (progOp == `FSP_PROG_WRITE) begin
							flashAddr <= progAddr;
							flashWdata <= progWdata; // R6
							flashWrStrobe <= 1'b1;
						end else begin
							flashAddr <= progAddr;
							flashRdStrobe <= 1'b1;
							progAck <= 1'b0;
							stateQ <= ST_PRD;
						end
					end
				end
				ST_PRD: begin
					// The array answers in the cycle after the strobe, as for self-reads.
					progRdWaitQ <= ~progRdWaitQ;
					if (progRdWaitQ) begin
						progRdata <= flashRdata;
						progAck <= 1'b1;
						stateQ <= ST_IDLE;
					end
				end
				ST_RD1: begin
					stateQ <= ST_RD2; // R14
				end
				ST_RD2: begin
					dataLowQ <= flashRdata[7:0]; // R14 R15
					dataHighQ <= flashRdata[13:8];
					readQ <= 1'b0; // R7
					cpuForceNop <= 1'b0;
					stateQ <= ST_IDLE;
				end
				ST_NOP1: begin
					stateQ <= ST_NOP2; // R19
				end
				ST_NOP2: begin
					cpuForceNop <= 1'b0;
					latchIdxQ <= 5'h00;
					timerQ <= 18'h00000;
					if (latchOnlyQ) begin
						writeQ <= 1'b0; // R21
						stateQ <= ST_IDLE;
					end else if (eraseQ) begin
						flashAddr <= {wordAddr[14:5], 5'h00}; // R23 R25
						flashEraseStrobe <= 1'b1;
						cpuStall <= 1'b1; // R20
						stateQ <= ST_WAIT;
					end else begin
						cpuStall <= 1'b1; // R20
						stateQ <= ST_STREAM;
					end
				end
				ST_STREAM: begin
					// Latches go out one word a cycle within the row.
					flashAddr <= {wordAddr[14:5], latchIdxQ}; // R25
					flashWdata <= latchBus[latchIdxQ*14 +: 14]; // R24
					flashWrStrobe <= 1'b1;
					latchIdxQ <= latchIdxQ + 5'h01;
					if (latchIdxQ == `FSP_LAST_LATCH) begin
						stateQ <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					timerQ <= timerQ + 18'h00001; // R3
					if (latchClear) begin
						writeQ <= 1'b0; // R7
						cpuStall <= 1'b0;
						stateQ <= ST_IDLE;
					end
				end
				default: begin
					stateQ <= ST_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### verilog/fsp_defines.vh
// Purpose: Shared constants of the flash self-program controller.
// Assumes: One clock at 100 MHz; registers are bytes in 32-bit words.
// Notes: Offsets are byte addresses on the register bus.
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

`define FSP_CLK_NS 10
`define FSP_OP_TIME_US 2000
`define FSP_OP_CYCLES ((`FSP_OP_TIME_US * 1000) / `FSP_CLK_NS)

`define FSP_OFF_ADDR_LOW 8'h00
`define FSP_OFF_ADDR_HIGH 8'h04
`define FSP_OFF_DATA_LOW 8'h08
`define FSP_OFF_DATA_HIGH 8'h0c
`define FSP_OFF_CTRL 8'h10
`define FSP_OFF_UNLOCK 8'h14
`define FSP_OFF_CONFIG 8'h18
`define FSP_OFF_STATUS 8'h1c

`define FSP_SEL_NONE 4'h0
`define FSP_SEL_ADDR_LOW 4'h1
`define FSP_SEL_ADDR_HIGH 4'h2
`define FSP_SEL_DATA_LOW 4'h3
`define FSP_SEL_DATA_HIGH 4'h4
`define FSP_SEL_CTRL 4'h5
`define FSP_SEL_UNLOCK 4'h6
`define FSP_SEL_CONFIG 4'h7
`define FSP_SEL_STATUS 4'h8

`define FSP_BIT_READ 0
`define FSP_BIT_WRITE 1
`define FSP_BIT_ALLOW 2
`define FSP_BIT_ABORT 3
`define FSP_BIT_LATCH_ONLY 4
`define FSP_BIT_ERASE 5
`define FSP_BIT_CFG_SEL 6

`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa

`define FSP_LATCH_BLANK 14'h3fff
`define FSP_LATCH_COUNT 32
`define FSP_LAST_LATCH 5'h1f

`define FSP_WP_OFF 2'h3
`define FSP_WP_LOW 2'h2
`define FSP_WP_HALF 2'h1
`define FSP_WP_LOW_END 15'h0200
`define FSP_WP_HALF_END 15'h1000

`define FSP_PROG_READ 2'h0
`define FSP_PROG_WRITE 2'h1
`define FSP_PROG_BULK 2'h2
`define FSP_PROG_CONFIG 2'h3

`endif

// ### testbench/fsp_flash_props.sv
// Purpose: Port-level checks of the flash self-program controller.
// Assumes: One clock; both resets synchronous and active low.
// Notes: The stall ceiling allows for the 32-word stream plus setup.
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_props #(
	parameter [17:0] OP_CYCLES = 18'd20
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic porn,
	input wire logic [7:0] adr_i,
	input wire logic we_i,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	input wire logic cpuForceNop,
	input wire logic cpuStall,
	input wire logic [14:0] flashAddr,
	input wire logic flashWrStrobe,
	input wire logic flashEraseStrobe,
	input wire logic progAck,
	input wire logic progDenied,
	input wire logic flashRdStrobe
);
	logic [17:0] stallCnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || !porn);
	always @(posedge clk) begin
		if (!resetn || !porn)
			stallCnt_q <= 18'h0;
		else
			stallCnt_q <= cpuStall ? stallCnt_q + 18'h1 : 18'h0;
	end
	sequence sNopPair;
		cpuForceNop ##1 cpuForceNop ##1 !cpuForceNop;
	endsequence
	a_unlock_zero: assert property (ack_o && adr_i == 8'h14 && !we_i |-> dat_o == 32'h0)
		else $error("unlock register read not zero");
	a_data_width: assert property (ack_o && adr_i == 8'h0c && !we_i |-> dat_o[31:6] == 26'h0)
		else $error("data high wider than 6 bits");
	a_addr_width: assert property (ack_o && adr_i == 8'h04 && !we_i |-> dat_o[31:7] == 25'h0)
		else $error("address high wider than 7 bits");
	a_nop_pair: assert property ($rose(cpuForceNop) |-> sNopPair)
		else $error("forced no-op span not two cycles");
	a_row_step: assert property (flashWrStrobe && $past(flashWrStrobe) |->
		flashAddr == $past(flashAddr) + 15'h1)
		else $error("row stream address did not step by one");
	a_row_last: assert property ($fell(flashWrStrobe) && cpuStall |->
		$past(flashAddr[4:0]) == 5'h1f)
		else $error("row stream did not end at latch 31");
	a_erase_stall: assert property (flashEraseStrobe |=> cpuStall [*3])
		else $error("erase did not stall the core");
	a_stall_min: assert property ($fell(cpuStall) |-> stallCnt_q >= OP_CYCLES)
		else $error("stall shorter than the timer");
	a_stall_max: assert property (stallCnt_q <= OP_CYCLES + 18'd40)
		else $error("stall ran past its bound");
	a_prog_denied: assert property (progAck && progDenied |-> !flashRdStrobe && !flashWrStrobe)
		else $error("denied programmer access reached the array");
endmodule
bind fsp_flash_ctrl fsp_flash_props #(.OP_CYCLES(OP_CYCLES)) chk_u (.clk, .resetn, .porn,
	.adr_i, .we_i, .ack_o, .dat_o, .cpuForceNop, .cpuStall, .flashAddr, .flashWrStrobe,
	.flashEraseStrobe, .progAck, .progDenied, .flashRdStrobe);
`default_nettype wire

// ### testbench/fsp_flash_model.sv
// Purpose: Behavioural flash array behind the controller.
// Assumes: Read data is wanted the cycle after the read strobe.
// Notes: Programming only clears bits, as real cells do.
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model (
	input wire logic clk,
	input wire logic [14:0] flashAddr,
	input wire logic [13:0] flashWdata,
	input wire logic flashCfgSpace,
	input wire logic flashRdStrobe,
	input wire logic flashWrStrobe,
	input wire logic flashEraseStrobe,
	input wire logic flashBulkStrobe,
	output logic [13:0] flashRdata
);
	logic [13:0] mem [0:32767];
	logic [13:0] rdQ = 14'h0;
	assign flashRdata = rdQ;
	initial begin
		for (int i = 0; i < 32768; i++)
			mem[i] = 14'(i) ^ 14'h2aaa;
	end
	// Outside a read the data toggles, so a sample one cycle late never looks valid.
	always @(posedge clk) begin
		rdQ <= flashRdStrobe ? mem[flashAddr] : ~rdQ;
		if (flashWrStrobe && !flashCfgSpace)
			mem[flashAddr] <= mem[flashAddr] & flashWdata;
		if (flashEraseStrobe)
			for (int i = 0; i < 32; i++)
				mem[{flashAddr[14:5], 5'(i)}] <= 14'h3fff;
		if (flashBulkStrobe)
			for (int i = 0; i < 32768; i++)
				mem[i] <= 14'h3fff;
	end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Register-level tests of the flash self-program controller.
// Assumes: Timer shortened to 20 cycles.
// Notes: Array contents are checked through self-reads and programmer reads.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errCount++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
	logic clk = 1'b0, resetn = 1'b0, porn = 1'b0, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
	logic progReq = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, q;
	logic [3:0] sel_i = 4'hf;
	logic [1:0] progOp = 2'h0;
	logic [14:0] progAddr = 15'h0;
	logic [13:0] progWdata = 14'h0, w;
	wire ack_o, cpuForceNop, cpuStall, flashCfgSpace, flashRdStrobe, flashWrStrobe;
	wire flashEraseStrobe, flashBulkStrobe, progAck, progDenied;
	wire [31:0] dat_o;
	wire [14:0] flashAddr;
	wire [13:0] flashWdata, flashRdata, progRdata;
	int errCount = 0, nCompared = 0;
	fsp_flash_ctrl #(.OP_CYCLES(18'd20)) dut_u (.clk, .resetn, .porn, .adr_i, .dat_i, .we_i,
		.sel_i, .cyc_i, .stb_i, .ack_o, .dat_o, .cpuForceNop, .cpuStall, .flashAddr, .flashWdata,
		.flashCfgSpace, .flashRdStrobe, .flashWrStrobe, .flashEraseStrobe, .flashBulkStrobe,
		.flashRdata, .progReq, .progOp, .progAddr, .progWdata, .progAck, .progDenied, .progRdata);
	fsp_flash_model mem_u (.clk, .flashAddr, .flashWdata, .flashCfgSpace, .flashRdStrobe,
		.flashWrStrobe, .flashEraseStrobe, .flashBulkStrobe, .flashRdata);
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic [13:0] pat(input logic [14:0] a);
		return a[13:0] ^ 14'h2aaa;
	endfunction
	task automatic report_and_stop;
		if (errCount == 0 && nCompared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		adr_i <= a;
		we_i <= wr;
		dat_i <= d;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do @(posedge clk); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic setA(input logic [14:0] a);
		wb(8'h00, 1'b1, {24'h0, a[7:0]});
		wb(8'h04, 1'b1, {25'h0, a[14:8]});
	endtask
	task automatic ulk(input logic [7:0] c);
		wb(8'h14, 1'b1, 32'h55);
		wb(8'h14, 1'b1, 32'haa);
		wb(8'h10, 1'b1, {24'h0, c});
	endtask
	task automatic rdw(input logic [14:0] a);
		setA(a);
		wb(8'h10, 1'b1, 32'h05);
		wb(8'h08, 1'b0, 32'h0);
		w[7:0] = q[7:0];
		wb(8'h0c, 1'b0, 32'h0);
		w[13:8] = q[5:0];
	endtask
	// The request is held until acknowledged, since the bus may win the cycle.
	task automatic prg(input logic [1:0] op, input logic [14:0] a, input logic [13:0] d);
		progOp <= op;
		progAddr <= a;
		progWdata <= d;
		progReq <= 1'b1;
		do @(posedge clk); while (progAck !== 1'b1);
		progReq <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		fork
			begin
				repeat (20000) @(posedge clk);
				errCount++;
				report_and_stop;
			end
		join_none
		repeat (20) @(posedge clk);
		porn <= 1'b1;
		resetn <= 1'b1;
		@(posedge clk);
		wb(8'h14, 1'b0, 32'h0); `CHK("unlock", 32'h0, q)
		wb(8'h10, 1'b0, 32'h0); `CHK("allow", 1'b0, q[2])
		rdw(15'h0125); `CHK("read", pat(15'h0125), w)
		wb(8'h10, 1'b0, 32'h0); `CHK("rdbit", 1'b0, q[0])
		wb(8'h10, 1'b1, 32'h45);
		`CHK("cfgsel", 1'b1, flashCfgSpace)
		setA(15'h0045);
		wb(8'h08, 1'b1, 32'h01);
		wb(8'h10, 1'b1, 32'h00);
		ulk(8'h12);
		wb(8'h10, 1'b0, 32'h0); `CHK("wrbit", 1'b0, q[1])
		setA(15'h0043);
		wb(8'h08, 1'b1, 32'hbc);
		wb(8'h0c, 1'b1, 32'h1a);
		// Write allow must already stand when the trigger is written.
		wb(8'h10, 1'b1, 32'h14);
		ulk(8'h16);
		setA(15'h0046);
		wb(8'h08, 1'b1, 32'h02);
		wb(8'h14, 1'b1, 32'h55);
		wb(8'h1c, 1'b0, 32'h0);
		wb(8'h14, 1'b1, 32'haa);
		wb(8'h10, 1'b1, 32'h16);
		setA(15'h0040);
		ulk(8'h06);
		rdw(15'h0043); `CHK("latch", pat(15'h0043) & 14'h1abc, w)
		rdw(15'h0045); `CHK("noallow", pat(15'h0045), w)
		rdw(15'h0046); `CHK("broken", pat(15'h0046), w)
		setA(15'h0060);
		ulk(8'h06);
		rdw(15'h0063); `CHK("blank", pat(15'h0063), w)
		setA(15'h005e);
		ulk(8'h26);
		rdw(15'h0043); `CHK("erase", 14'h3fff, w)
		prg(2'h3, 15'h0, 14'h0004);
		setA(15'h0060);
		ulk(8'h26);
		rdw(15'h0063); `CHK("wprot", pat(15'h0063), w)
		prg(2'h1, 15'h0100, 14'h0155); `CHK("pgwr", 1'b0, progDenied)
		prg(2'h0, 15'h0100, 14'h0); `CHK("pgrd", pat(15'h0100) & 14'h0155, progRdata)
		prg(2'h3, 15'h0, 14'h0003);
		prg(2'h0, 15'h0125, 14'h0); `CHK("deny", 1'b1, progDenied)
		rdw(15'h0125); `CHK("selfrd", pat(15'h0125), w)
		prg(2'h2, 15'h0, 14'h0);
		wb(8'h18, 1'b0, 32'h0); `CHK("cfg", 3'h7, q[2:0])
		prg(2'h0, 15'h0125, 14'h0); `CHK("bulk", 14'h3fff, progRdata)
		setA(15'h0060);
		ulk(8'h06);
		repeat (5) @(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		wb(8'h10, 1'b0, 32'h0); `CHK("abort", 1'b1, q[3])
		report_and_stop;
	end
endmodule
`default_nettype wire
